// *** rtl/acq_map.svh ***
// Address map, field positions, reset values and timing counts of the
// acquisition buffer. Assumes a 32-bit AXI4-Lite register window.
`ifndef ACQ_MAP_SVH
`define ACQ_MAP_SVH
// Register byte offsets
`define ACQ_SETUP_OFS     8'h00
`define ACQ_GROUP_OFS     8'h04
`define ACQ_STOP_OFS      8'h08
`define ACQ_PTR_MOVE_OFS  8'h0C
`define ACQ_FORMAT_OFS    8'h10
`define ACQ_READOUT_OFS   8'h14
`define ACQ_STATUS_OFS    8'h18
`define ACQ_RATE_OFS      8'h1C
`define ACQ_VALUE_OFS     8'h20
`define ACQ_VALUE_SEL_OFS 8'h24
// Status word field positions
`define ST_COUNT_LSB      0
`define ST_TRIG_LSB       24
`define ST_OVERRUN_BIT    28
`define ST_LOGGING_BIT    31
// Readout command fields
`define RD_LINES_LSB      0
`define RD_MODE_LSB       16
`define FMT_ALL_BIT       31
// Codes and reset values
`define FMT_FLOAT_LE      16'h04E9
`define RD_MODE_PTR       16'h1909
`define RATE_RESET        16'h18AD
`define SIG_GROSS         16'h00D6
`define SIG_MIN           16'h00CC
`define SIG_MAX           16'h00CD
`define SIG_P2P           16'h00D9
`define TRIG_ACTIVE       4'h2
`define TRIG_ENDED        4'h3
`define ERR_FLOAT         32'h612D_78EC
`define HDR_BYTE0         8'h23
`define HDR_BYTE1         8'h30
`define CR_BYTE           8'h0D
`define LF_BYTE           8'h0A
`define LINE_BYTES        4
`define FIFO_STD_BYTES    5242880
`define FIFO_MAX_BYTES    15728640
// Analog value refresh: period in ms, clock in MHz
`define REFRESH_MS        500
`define CLK_MHZ           200
`define REFRESH_CYCLES    (`REFRESH_MS * 1000 * `CLK_MHZ)
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

// *** rtl/acq_pkg.sv ***
// Types shared by the acquisition buffer modules.
// Assumes the constants of acq_map.svh.
package acq_pkg;
  // One incoming measured line of a rate group
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] value;
  } sample_t;
  // Live analog values sampled by the refresh holder
  typedef struct packed {
    logic [31:0] gross;
    logic [31:0] min;
    logic [31:0] max;
    logic [31:0] p2p;
  } live_t;
  // Readout states, Gray along the usual path except RO_TAIL back to RO_IDLE
  typedef enum logic [2:0] {
    RO_IDLE  = 3'b000,
    RO_HDR   = 3'b001,
    RO_WAIT  = 3'b011,
    RO_FETCH = 3'b010,
    RO_LOAD  = 3'b110,
    RO_SEND  = 3'b111,
    RO_TAIL  = 3'b101
  } ro_state_t;
endpackage

// *** rtl/acq_group_fifo.sv ***
// One measurement FIFO of a rate group with its logging state.
// Assumes start, stop and pointer moves are single-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "acq_map.svh"
module acq_group_fifo
  import acq_pkg::*;
#(
  parameter int DEPTH = `FIFO_STD_BYTES / `LINE_BYTES
)
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Control
  input  wire logic               start,
  input  wire logic signed [31:0] start_count,
  input  wire logic               stop,
  input  wire logic               move,
  input  wire logic signed [31:0] move_offset,
  // Data
  input  wire sample_t            sample,
  input  wire logic               rd_en,
  output logic [31:0]             rd_data,
  // State
  output logic [31:0]             count,
  output logic                    logging,
  output logic                    overrun
);
  localparam int AW = $clog2(DEPTH);
  localparam logic signed [33:0] DEPTH_S = 34'(DEPTH);

  initial
  begin
    if (DEPTH < 2 || DEPTH > `FIFO_MAX_BYTES / `LINE_BYTES)
      $error("acq_group_fifo: DEPTH out of range");
  end

  logic [31:0]             mem [DEPTH];
  logic [AW-1:0]           wr_ptr;
  logic [AW-1:0]           rd_ptr;
  logic                    latest;
  logic signed [31:0]      lines_left;
  logic                    full;
  logic                    wr;
  logic                    wr_acc;
  logic signed [33:0]      next_rd;
  logic [31:0]             wdata;

  assign full   = count == 32'(DEPTH);
  assign wr     = logging && sample.valid;
  assign wr_acc = wr && (latest || !full);
  assign wdata  = sample.err ? `ERR_FLOAT : sample.value;

  // Read pointer moves by reads and by unchecked host offsets
  always_comb
  begin
    next_rd = 34'(rd_ptr) + (rd_en ? 34'sd1 : 34'sd0) + (move ? 34'(move_offset) : 34'sd0);
    if (next_rd >= DEPTH_S)
      next_rd = next_rd - DEPTH_S;
    else if (next_rd < 0)
      next_rd = next_rd + DEPTH_S;
  end

  // Line storage; latest mode overwrites slot zero only
  always_ff @(posedge aclk)
  begin
    if (wr_acc)
      mem[latest ? '0 : wr_ptr] <= wdata;
    if (rd_en)
      rd_data <= mem[latest ? '0 : rd_ptr];
  end

  // Pointers and fill level
  always_ff @(posedge aclk)
  begin
    if (!aresetn || start)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (latest)
    begin
      count <= wr_acc ? 32'd1 : count;
    end
    else
    begin
      if (wr_acc)
        wr_ptr <= (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      rd_ptr <= AW'(next_rd);
      count  <= count + (wr_acc ? 32'd1 : 32'd0) - (rd_en ? 32'd1 : 32'd0)
                - (move ? move_offset : 32'sd0);
    end
  end

  // Logging state and finite line count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      logging    <= 1'b0;
      latest     <= 1'b0;
      lines_left <= '0;
    end
    else if (start)
    begin
      logging    <= 1'b1;
      latest     <= start_count == -32'sd1;
      lines_left <= start_count;
    end
    else if (stop)
      logging <= 1'b0;
    else if (wr_acc && lines_left > 0)
    begin
      lines_left <= lines_left - 32'sd1;
      if (lines_left == 32'sd1)
        logging <= 1'b0;
    end
  end

  // Overrun: a write against a full FIFO wins over the clear by setup
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overrun <= 1'b0;
    else if (wr && !latest && full)
      overrun <= 1'b1;
    else if (start)
      overrun <= 1'b0;
  end
endmodule
`default_nettype wire

// *** rtl/acq_value_hold.sv ***
// Holds current analog values and refreshes them on a fixed period.
// Assumes live values are stable inputs in the aclk domain.
`timescale 1ns/10ps
`default_nettype none
`include "acq_map.svh"
module acq_value_hold
  import acq_pkg::*;
#(
  parameter int REFRESH = `REFRESH_CYCLES
)
(
  // Clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Live and held values
  input  wire live_t live,
  input  wire logic  live_ok,
  output live_t      held
);
  initial
  begin
    if (REFRESH < 1)
      $error("acq_value_hold: REFRESH must be positive");
  end

  logic [31:0] tick;

  // Period counter; a capture happens right after reset too
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick <= '0;
    else
      tick <= (tick == 32'(REFRESH - 1)) ? '0 : tick + 32'd1;
  end

  // Between refreshes every query sees the same value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      held <= {4{`ERR_FLOAT}};
    else if (tick == '0)
      held <= live_ok ? live : {4{`ERR_FLOAT}};
  end
endmodule
`default_nettype wire

// *** rtl/acquisition_fifo_readout.sv ***
// Acquisition buffer with readout stream and AXI4-Lite register access.
// Assumes samples and live values are synchronous to aclk.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "acq_map.svh"
module acquisition_fifo_readout
  import acq_pkg::*;
#(
  parameter int GROUPS  = 3,
  parameter int DEPTH   = `FIFO_STD_BYTES / `LINE_BYTES,
  parameter int REFRESH = `REFRESH_CYCLES
)
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Measured lines per rate group
  input  wire sample_t [GROUPS-1:0]   sample_in,
  // Live current values and which derived signals exist upstream
  input  wire live_t                  live_in,
  input  wire logic                   live_ok,
  input  wire logic [2:0]             signal_created,
  // Readout byte stream
  output logic                        out_valid,
  output logic [7:0]                  out_byte,
  input  wire logic                   out_ready,
  output logic                        readout_busy
);
  initial
  begin
    if (GROUPS < 1 || GROUPS > 3)
      $error("acquisition_fifo_readout: GROUPS must be 1 to 3");
  end

  // Group number to array index; absent or unknown groups fall to zero
  function automatic int grp(input logic [1:0] sel);
    return (int'(sel) < GROUPS) ? int'(sel) : 0;
  endfunction

  // Write data merged under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // Registers and write handshake state
  logic [7:0]              aw_addr;
  logic                    aw_held;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    w_held;
  logic                    do_write;
  logic [31:0]             wval;
  logic [31:0]             sel_m;
  logic [31:0]             rate_m;
  logic [1:0]              group_sel;
  logic [15:0]             fmt   [GROUPS];
  logic [15:0]             rate  [GROUPS];
  logic [15:0]             value_sel;
  // Command pulses toward the group FIFOs
  logic [GROUPS-1:0]       start_p;
  logic                    stop_p;
  logic [GROUPS-1:0]       move_p;
  logic signed [31:0]      cmd_arg;
  logic [GROUPS-1:0]       rd_en;
  logic [31:0]             rd_data [GROUPS];
  logic [31:0]             count   [GROUPS];
  logic [GROUPS-1:0]       logging;
  logic [GROUPS-1:0]       overrun;
  live_t                   held;
  // Readout engine
  ro_state_t               state;
  int                      ro_grp;
  logic [15:0]             lines_rem;
  logic [1:0]              idx;
  logic [31:0]             shift;
  logic                    ro_start;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wval     = merge(32'h0000_0000, w_data, w_strb);
  assign sel_m    = merge({16'd0, value_sel}, w_data, w_strb);
  assign rate_m   = merge({16'd0, rate[grp(group_sel)]}, w_data, w_strb);

  // Address and data are taken in either order, then answered together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] == 2'b00 && aw_addr <= `ACQ_VALUE_SEL_OFS
                         && aw_addr != `ACQ_STATUS_OFS && aw_addr != `ACQ_VALUE_OFS)
                        ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Command pulses last one cycle, raised by the accepted write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_p  <= '0;
      stop_p   <= 1'b0;
      move_p   <= '0;
      ro_start <= 1'b0;
      cmd_arg  <= '0;
    end
    else
    begin
      start_p  <= '0;
      stop_p   <= 1'b0;
      move_p   <= '0;
      ro_start <= 1'b0;
      if (do_write)
      begin
        cmd_arg <= wval;
        case (aw_addr)
          `ACQ_SETUP_OFS:
            start_p[grp(group_sel)] <= 1'b1;
          `ACQ_STOP_OFS:
            stop_p <= 1'b1;
          `ACQ_PTR_MOVE_OFS:
            if (int'(group_sel) < GROUPS)
              move_p[grp(group_sel)] <= 1'b1;
          `ACQ_READOUT_OFS:
            ro_start <= wval[`RD_MODE_LSB +: 16] == `RD_MODE_PTR;
          default:
            ;
        endcase
      end
    end
  end

  // Settings: group selection, format, rate and value signal
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      group_sel <= '0;
      value_sel <= `SIG_GROSS;
      for (int g = 0; g < GROUPS; g++)
      begin
        fmt[g]  <= `FMT_FLOAT_LE;
        rate[g] <= `RATE_RESET;
      end
    end
    else if (do_write)
    begin
      case (aw_addr)
        `ACQ_GROUP_OFS:
          group_sel <= w_strb[0] ? w_data[1:0] : group_sel;
        `ACQ_VALUE_SEL_OFS:
          value_sel <= sel_m[15:0];
        `ACQ_RATE_OFS:
          rate[grp(group_sel)] <= rate_m[15:0];
        `ACQ_FORMAT_OFS:
          if (wval[15:0] == `FMT_FLOAT_LE)
            for (int g = 0; g < GROUPS; g++)
              if (wval[`FMT_ALL_BIT] || g == grp(group_sel))
                fmt[g] <= wval[15:0];
        default:
          ;
      endcase
    end
  end

  // Current value selection; missing or uncreated signals give the error value
  function automatic logic [31:0] cur_value(input logic [15:0] sel);
    case (sel)
      `SIG_GROSS: return held.gross;
      `SIG_MIN:   return signal_created[0] ? held.min : `ERR_FLOAT;
      `SIG_MAX:   return signal_created[1] ? held.max : `ERR_FLOAT;
      `SIG_P2P:   return signal_created[2] ? held.p2p : `ERR_FLOAT;
      default:    return `ERR_FLOAT;
    endcase
  endfunction

  // Read channel: data is latched at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= '0;
      case (s_axi_araddr)
        `ACQ_GROUP_OFS:
          s_axi_rdata <= {30'd0, group_sel};
        `ACQ_STATUS_OFS:
        begin
          s_axi_rdata[`ST_COUNT_LSB +: 24]   <= count[grp(group_sel)][23:0];
          s_axi_rdata[`ST_TRIG_LSB +: 4]     <= logging[grp(group_sel)]
                                                ? `TRIG_ACTIVE : `TRIG_ENDED;
          s_axi_rdata[`ST_OVERRUN_BIT]       <= overrun[grp(group_sel)];
          s_axi_rdata[`ST_LOGGING_BIT]       <= logging[grp(group_sel)];
        end
        `ACQ_FORMAT_OFS:
          s_axi_rdata <= {16'd0, fmt[grp(group_sel)]};
        `ACQ_RATE_OFS:
          s_axi_rdata <= {16'd0, rate[grp(group_sel)]};
        `ACQ_VALUE_SEL_OFS:
          s_axi_rdata <= {16'd0, value_sel};
        `ACQ_VALUE_OFS:
          s_axi_rdata <= cur_value(value_sel);
        `ACQ_SETUP_OFS, `ACQ_STOP_OFS, `ACQ_PTR_MOVE_OFS, `ACQ_READOUT_OFS:
          s_axi_rdata <= '0;
        default:
          s_axi_rresp <= `RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // One FIFO per rate group
  genvar gi;
  generate
    for (gi = 0; gi < GROUPS; gi++)
    begin : g_fifo
      acq_group_fifo #(.DEPTH(DEPTH)) u_fifo (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (start_p[gi]),
        .start_count (cmd_arg),
        .stop        (stop_p),
        .move        (move_p[gi]),
        .move_offset (cmd_arg),
        .sample      (sample_in[gi]),
        .rd_en       (rd_en[gi]),
        .rd_data     (rd_data[gi]),
        .count       (count[gi]),
        .logging     (logging[gi]),
        .overrun     (overrun[gi])
      );
      assign rd_en[gi] = (state == RO_FETCH) && (ro_grp == gi);
    end
  endgenerate

  acq_value_hold #(.REFRESH(REFRESH)) u_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .live    (live_in),
    .live_ok (live_ok),
    .held    (held)
  );

  // Readout stream: header, values low byte first, then CR LF
  always_ff @(posedge aclk)
  begin
    if (!aresetn || stop_p)
    begin
      state        <= RO_IDLE;
      out_valid    <= 1'b0;
      out_byte     <= '0;
      readout_busy <= 1'b0;
      ro_grp       <= 0;
      lines_rem    <= '0;
      idx          <= '0;
      shift        <= '0;
    end
    else
    begin
      case (state)
        RO_IDLE:
          if (ro_start)
          begin
            ro_grp       <= grp(group_sel);
            lines_rem    <= cmd_arg[`RD_LINES_LSB +: 16];
            out_byte     <= `HDR_BYTE0;
            out_valid    <= 1'b1;
            idx          <= '0;
            readout_busy <= 1'b1;
            state        <= RO_HDR;
          end
        RO_HDR:
          if (out_ready)
          begin
            if (idx == 2'd0)
            begin
              out_byte <= `HDR_BYTE1;
              idx      <= 2'd1;
            end
            else if (lines_rem == '0)
            begin
              out_byte <= `CR_BYTE;
              state    <= RO_TAIL;
            end
            else
            begin
              out_valid <= 1'b0;
              state     <= RO_WAIT;
            end
          end
        RO_WAIT:
          if (count[ro_grp] != '0)
            state <= RO_FETCH;
        RO_FETCH:
          state <= RO_LOAD;
        RO_LOAD:
        begin
          shift     <= rd_data[ro_grp];
          out_byte  <= rd_data[ro_grp][7:0];
          out_valid <= 1'b1;
          idx       <= '0;
          state     <= RO_SEND;
        end
        RO_SEND:
          if (out_ready)
          begin
            if (idx == 2'd3)
            begin
              lines_rem <= lines_rem - 16'd1;
              if (lines_rem == 16'd1)
              begin
                out_byte <= `CR_BYTE;
                state    <= RO_TAIL;
              end
              else
              begin
                out_valid <= 1'b0;
                state     <= RO_WAIT;
              end
            end
            else
            begin
              idx      <= idx + 2'd1;
              out_byte <= shift[8*(idx + 2'd1) +: 8];
            end
          end
        RO_TAIL:
          if (out_ready)
          begin
            if (out_byte == `CR_BYTE)
              out_byte <= `LF_BYTE;
            else
            begin
              out_valid    <= 1'b0;
              readout_busy <= 1'b0;
              state        <= RO_IDLE;
            end
          end
        default:
          state <= RO_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test/acq_checker.sv ***
// Checker for the acquisition buffer: register answers and readout stream.
// Bound to the top module; sees only its ports, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "acq_map.svh"
module acq_checker
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Register bus handshakes
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Readout stream
  input wire logic       out_valid,
  input wire logic [7:0] out_byte,
  input wire logic       out_ready,
  input wire logic       readout_busy
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Only one write and one read may be in flight
  a_aw_held: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  a_ar_held: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  // Stream framing; a stop in mid-stream is never issued by the bench
  a_hdr_first: assert property ($rose(readout_busy) |-> ##[0:4] (out_valid && out_byte == `HDR_BYTE0))
    else $error("readout header missing");
  a_lf_ends: assert property ($fell(readout_busy) && $past(out_valid) && $past(out_ready) |-> $past(out_byte) == `LF_BYTE)
    else $error("readout ended without line feed");
  a_quiet_idle: assert property (!readout_busy |-> !out_valid)
    else $error("byte offered outside readout");
  a_out_stands: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("stream byte changed before taken");
endmodule
bind acquisition_fifo_readout acq_checker u_chk (.*);
`default_nettype wire

// *** test/acq_byte_sink.sv ***
// Host side of the readout byte stream: collects every byte taken.
// Assumes one clock; when slow is high it accepts one cycle in four.
`timescale 1ns/10ps
`default_nettype none
module acq_byte_sink
(
  // Clock and stream
  input wire logic       aclk,
  input wire logic       out_valid,
  input wire logic [7:0] out_byte,
  input wire logic       slow,
  output var logic       out_ready
);
  logic [7:0] got[$];
  logic [1:0] tick = 2'h0;
  initial out_ready = 1'b0;
  // Stalls make the stream hold its bytes
  always @(posedge aclk)
  begin
    tick <= tick + 2'h1;
    out_ready <= !slow || tick == 2'h0;
    if (out_valid && out_ready) got.push_back(out_byte);
  end
endmodule
`default_nettype wire

// *** test/acquisition_fifo_readout_tb.sv ***
// Self-checking bench for the acquisition buffer.
// Assumes a small FIFO depth and refresh period to keep the run short.
`timescale 1ns/10ps
`default_nettype none
`include "acq_map.svh"
module acquisition_fifo_readout_tb
  import acq_pkg::*;
;
  logic aclk = 0, aresetn = 0, live_ok = 1, slow = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, out_valid, out_ready, readout_busy;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, out_byte;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] signal_created = 0;
  sample_t [2:0] sample_in = '0;
  live_t live_in = '0;
  int failures = 0, checked = 0;
  acquisition_fifo_readout #(.DEPTH(16), .REFRESH(8)) dut (.*);
  acq_byte_sink sink (.*);
  always #2.5 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa = 1, pw = 1;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (pa || pw)
    begin
      @(posedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {pa, pw};
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    {d, r} = {s_axi_rdata, s_axi_rresp};
  endtask
  task automatic push(input logic e, input logic [31:0] v);
    @(posedge aclk);
    sample_in[0] <= '{1'b1, e, v};
    @(posedge aclk);
    sample_in[0] <= '0;
  endtask
  // Logging, overrun, trigger state and unsent count in one word
  task automatic stat(input logic l, o, input logic [3:0] t, input logic [23:0] n);
    rd(`ACQ_STATUS_OFS);
    chk(d & 32'h9FFF_FFFF, {l, 2'b00, o, t, n});
  endtask
  task automatic t_reg;
    rd(`ACQ_RATE_OFS);
    chk(d, 32'(`RATE_RESET));
    wr(`ACQ_GROUP_OFS, 32'h0000_0001);
    wr(`ACQ_RATE_OFS, 32'h0000_189C);
    rd(`ACQ_RATE_OFS);
    chk(d, 32'h0000_189C);
    wr(`ACQ_FORMAT_OFS, {16'h8000, `FMT_FLOAT_LE});
    wr(`ACQ_FORMAT_OFS, 32'h0000_0001);
    wr(`ACQ_GROUP_OFS, 32'h0000_0002);
    rd(`ACQ_FORMAT_OFS);
    chk(d, 32'(`FMT_FLOAT_LE));
    wr(`ACQ_GROUP_OFS, 32'h0000_0000);
    chk(32'(r), 32'(`RESP_OKAY));
    wr(`ACQ_STATUS_OFS, 32'h0000_0000);
    chk(32'(r), 32'(`RESP_SLVERR));
    rd(`ACQ_RATE_OFS);
    chk(d, 32'(`RATE_RESET));
    rd(8'h28);
    chk(32'(r), 32'(`RESP_SLVERR));
    $display("t_reg done");
  endtask
  // Finite run stops after two lines; a third is not stored
  task automatic t_fin;
    wr(`ACQ_SETUP_OFS, 32'h0000_0002);
    stat(1, 0, `TRIG_ACTIVE, 0);
    repeat (3) push(0, 32'h3F80_0000);
    stat(0, 0, `TRIG_ENDED, 2);
    wr(`ACQ_SETUP_OFS, 32'h0000_0000);
    repeat (17) push(0, 32'h4000_0000);
    stat(1, 1, `TRIG_ACTIVE, 16);
    wr(`ACQ_SETUP_OFS, 32'h0000_0000);
    stat(1, 0, `TRIG_ACTIVE, 0);
    $display("t_fin done");
  endtask
  // Two lines asked with one stored: the stream waits for the second
  task automatic t_rdo;
    logic [7:0] e [12] = '{`HDR_BYTE0, `HDR_BYTE1, 8'h00, 8'h00, 8'h20, 8'h41,
                           8'hEC, 8'h78, 8'h2D, 8'h61, `CR_BYTE, `LF_BYTE};
    push(0, 32'h4120_0000);
    stat(1, 0, `TRIG_ACTIVE, 1);
    wr(`ACQ_READOUT_OFS, {`RD_MODE_PTR, 16'h0002});
    push(1, 32'h0000_0000);
    do @(posedge aclk); while (readout_busy);
    chk(sink.got.size(), 12);
    foreach (e[i]) chk(32'(sink.got[i]), 32'(e[i]));
    stat(1, 0, `TRIG_ACTIVE, 0);
    wr(`ACQ_PTR_MOVE_OFS, 32'hFFFF_FFFE);
    stat(1, 0, `TRIG_ACTIVE, 2);
    wr(`ACQ_READOUT_OFS, {16'h1908, 16'h0001});
    chk(32'(readout_busy), 0);
    $display("t_rdo done");
  endtask
  task automatic t_lat;
    wr(`ACQ_SETUP_OFS, 32'hFFFF_FFFF);
    repeat (3) push(0, 32'h4040_0000);
    stat(1, 0, `TRIG_ACTIVE, 1);
    wr(`ACQ_STOP_OFS, 32'h0000_0000);
    stat(0, 0, `TRIG_ENDED, 1);
    @(posedge aclk);
    live_in <= '{32'h4110_0000, 32'h3F00_0000, 32'h4000_0000, 32'h3F80_0000};
    repeat (10) @(posedge aclk);
    rd(`ACQ_VALUE_OFS);
    chk(d, 32'h4110_0000);
    wr(`ACQ_VALUE_SEL_OFS, 32'(`SIG_MIN));
    rd(`ACQ_VALUE_OFS);
    chk(d, `ERR_FLOAT);
    {signal_created, live_ok} <= 4'b0010;
    repeat (10) @(posedge aclk);
    rd(`ACQ_VALUE_OFS);
    chk(d, `ERR_FLOAT);
    $display("t_lat done");
  endtask
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence, then a watchdog against a hung handshake
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_reg;
    t_fin;
    t_rdo;
    t_lat;
    conclude;
  end
  initial
  begin
    #100000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
